// *** egress_grant_map.svh ***
`ifndef EGRESS_GRANT_MAP_SVH
`define EGRESS_GRANT_MAP_SVH

// register byte offsets
`define CTRL_OFS 8'h00
`define SIDE_OFS 8'h04
`define STATUS_OFS 8'h08

// control register fields and reset values
`define CTRL_MODE_BIT 0
`define CTRL_PRIO_LSB 1
`define CTRL_COLOR_LSB 4
`define CTRL_RST 32'h0000_0006
`define SIDE_HI_LSB 0
`define SIDE_LO_LSB 4
`define SIDE_RST 32'h0000_0000

// status register fields
`define STAT_EXT_BIT 0
`define STAT_PRIO_LSB 1
`define STAT_PORT_LSB 4
`define STAT_TYPE_LSB 8
`define STAT_GT_BIT 12

// 8b/10b characters
`define CHAR_D21_5 8'hb5
`define CHAR_K28_1 8'h3c
`define CHAR_K28_5 8'hbc

// byte positions in a logical lane unit
`define BYTE_H0 0
`define BYTE_H1 1
`define BYTE_H2 2
`define BYTE_SIDE 5
`define BYTE_FLOW 6
`define BYTE_SYNC 7
`define LANE_BYTES 10

// flywheel codes and multicast period in packet cycles
`define SP_TYPE_MC 3'h4
`define MC_PERIOD 61

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** egress_grant_pkg.sv ***
`default_nettype none

package egress_grant_pkg;
    typedef logic [7:0] lane_byte_t;
    typedef logic [2:0] sp_code_t;
    typedef logic [1:0] axi_resp_t;
endpackage

`default_nettype wire

// *** egress_flywheels.sv ***
`include "egress_grant_map.svh"
`default_nettype none

module egress_flywheels (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic pkt_cycle,
    input wire logic [1:0] num_prio_m1,
    input wire logic [7:0] mc_grant,
    output logic ext_fw_ff,
    output logic [1:0] prio_fw_ff,
    output egress_grant_pkg::sp_code_t sp_port_ff,
    output egress_grant_pkg::sp_code_t sp_type_ff,
    output logic grant_type
);
    logic [5:0] mc_cnt_ff;
    logic [7:0] mc_sent_ff;
    logic mc_due;
    logic mc_changed;
    logic type_is_mc;
    logic port_wraps;
    logic [1:0] nxt_prio;
    egress_grant_pkg::sp_code_t nxt_port;
    egress_grant_pkg::sp_code_t nxt_type;

    assign mc_due = (mc_cnt_ff == 6'(`MC_PERIOD - 1));
    assign mc_changed = (mc_grant != mc_sent_ff);
    assign grant_type = mc_due | mc_changed;
    assign type_is_mc = (sp_type_ff == `SP_TYPE_MC);
    assign port_wraps = (sp_port_ff == 3'h7);

    // the combined six-bit count runs to 100000 then back to zero
    assign nxt_port = type_is_mc ? 3'h0 : sp_port_ff + 3'h1;
    assign nxt_type = type_is_mc ? 3'h0 :
                      !port_wraps ? sp_type_ff :
                      (sp_type_ff[1:0] == num_prio_m1) ? `SP_TYPE_MC :
                      sp_type_ff + 3'h1;
    assign nxt_prio = (prio_fw_ff == num_prio_m1) ? 2'h0 : prio_fw_ff + 2'h1;

    // flywheels keep turning in multicast slots too
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_fw_ff <= 1'b0;
            prio_fw_ff <= 2'h0;
            sp_port_ff <= 3'h0;
            sp_type_ff <= 3'h0;
            mc_cnt_ff <= 6'h0;
            mc_sent_ff <= 8'h00;
        end else if (pkt_cycle) begin
            ext_fw_ff <= ~ext_fw_ff;
            prio_fw_ff <= ext_fw_ff ? nxt_prio : prio_fw_ff;
            sp_port_ff <= nxt_port;
            sp_type_ff <= nxt_type;
            mc_cnt_ff <= mc_due ? 6'h0 : mc_cnt_ff + 6'h1;
            mc_sent_ff <= grant_type ? mc_grant : mc_sent_ff;
        end
    end
endmodule

`default_nettype wire

// *** egress_axil_regs.sv ***
`include "egress_grant_map.svh"
`default_nettype none

module egress_axil_regs (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output egress_grant_pkg::axi_resp_t s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output egress_grant_pkg::axi_resp_t s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] status,
    output logic [31:0] ctrl_ff,
    output logic [31:0] side_ff
);
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic do_wr;
    logic wr_ctrl;
    logic wr_side;
    logic [31:0] wmask;
    logic [31:0] rd_word;
    logic rd_hit;

    assign do_wr = aw_got_ff & w_got_ff & ~s_axi_bvalid;
    assign wr_ctrl = do_wr & (awaddr_ff == `CTRL_OFS);
    assign wr_side = do_wr & (awaddr_ff == `SIDE_OFS);
    assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    assign rd_hit = (s_axi_araddr == `CTRL_OFS) | (s_axi_araddr == `SIDE_OFS) |
                    (s_axi_araddr == `STATUS_OFS);
    assign rd_word = (s_axi_araddr == `CTRL_OFS) ? ctrl_ff :
                     (s_axi_araddr == `SIDE_OFS) ? side_ff :
                     (s_axi_araddr == `STATUS_OFS) ? status : 32'h0;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
            ctrl_ff <= `CTRL_RST;
            side_ff <= `SIDE_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_ff <= s_axi_awaddr;
                aw_got_ff <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                w_got_ff <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_ctrl | wr_side) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (wr_ctrl) begin
                ctrl_ff <= ((ctrl_ff & ~wmask) | (wdata_ff & wmask)) & 32'h0000_0037;
            end
            if (wr_side) begin
                side_ff <= ((side_ff & ~wmask) | (wdata_ff & wmask)) & 32'h0000_00ff;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// *** egress_idle_header_grant_formatter.sv ***
// The address map and the AXI4-Lite slave port are this design's own decisions.
`include "egress_grant_map.svh"
`default_nettype none

// Function
// - third header byte only in 512 mode
// - low channel byte 7 carries K28.5
// - unused idle bytes carry D21.5 fill
// - side nibble sent twice in byte
// - color bits 4:5, parity bit 1
// - grant type defaults to subport grants
// - multicast grants every 61 packet cycles
// - multicast grants sent on status change
// - protection field always zero
// - low bit 0 shows extended flywheel
// - low bits 6:7 show priority flywheel
// - subport multicast is AND over range
// - subport queue grants for ports n, n+1
// - subport multicast grants at flywheel four
// - multicast grants, high element high nibble
// - 512 mode byte b: ports n+2, n+3
// - 256 mode low grants per eight ports
// - 512 mode low grants in two bytes
// - grant bytes shared by all packet kinds
// - flow byte: grant, flywheel fields
// - type codes 0-3 priority, 4 multicast
// - port flywheel selects port pair/quad
// - extended and priority flywheels advance
// - subport flywheels advance and wrap
// - flywheels advance during multicast slots
module egress_idle_header_grant_formatter (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic pkt_cycle,
    input wire logic mem_grant,
    input wire logic [7:0] mc_grant,
    input wire logic [127:0] oq_grant,
    input wire logic [511:0] sp_oq_grant,
    input wire logic [127:0] sp_mc_grant,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output egress_grant_pkg::axi_resp_t s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output egress_grant_pkg::axi_resp_t s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic frame_valid_ff,
    output logic [79:0] hi_master_ff,
    output logic [9:0] hi_master_k_ff,
    output logic [79:0] lo_master_ff,
    output logic [9:0] lo_master_k_ff,
    output logic [79:0] hi_slave_ff,
    output logic [9:0] hi_slave_k_ff,
    output logic [79:0] lo_slave_ff,
    output logic [9:0] lo_slave_k_ff,
    output logic [7:0] hi_grant_a_ff,
    output logic [7:0] hi_grant_b_ff,
    output logic [7:0] lo_grant_a_ff,
    output logic [7:0] lo_grant_b_ff
);
    // ------------------------------------------------------------
    // registers and flywheels
    // ------------------------------------------------------------
    logic [31:0] ctrl_ff;
    logic [31:0] side_ff;
    logic [31:0] status;
    logic gt_last_ff;
    logic mode_512;
    logic [1:0] num_prio_m1;
    logic [1:0] color;
    logic [3:0] side_hi;
    logic [3:0] side_lo;
    logic ext_fw;
    logic [1:0] prio_fw;
    egress_grant_pkg::sp_code_t sp_port;
    egress_grant_pkg::sp_code_t sp_type;
    logic grant_type;

    assign mode_512 = ctrl_ff[`CTRL_MODE_BIT];
    assign num_prio_m1 = ctrl_ff[`CTRL_PRIO_LSB +: 2];
    assign color = ctrl_ff[`CTRL_COLOR_LSB +: 2];
    assign side_hi = side_ff[`SIDE_HI_LSB +: 4];
    assign side_lo = side_ff[`SIDE_LO_LSB +: 4];
    assign status = {19'h0, gt_last_ff, 1'b0, sp_type, 1'b0, sp_port, 1'b0, prio_fw, ext_fw};

    egress_axil_regs u_regs (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .status(status),
        .ctrl_ff(ctrl_ff),
        .side_ff(side_ff)
    );

    egress_flywheels u_fly (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pkt_cycle(pkt_cycle),
        .num_prio_m1(num_prio_m1),
        .mc_grant(mc_grant),
        .ext_fw_ff(ext_fw),
        .prio_fw_ff(prio_fw),
        .sp_port_ff(sp_port),
        .sp_type_ff(sp_type),
        .grant_type(grant_type)
    );

    // ------------------------------------------------------------
    // subport multicast aggregation
    // ------------------------------------------------------------
    logic [3:0] spmc_lower;
    logic [3:0] spmc_upper;

    genvar p;
    generate
        for (p = 0; p < 4; p++) begin : g_spmc
            // half width follows the arrangement: 8 ports or 16 ports
            assign spmc_lower[p] = mode_512 ? &sp_mc_grant[p*32 +: 16] :
                                   &sp_mc_grant[p*32 +: 8];
            assign spmc_upper[p] = mode_512 ? &sp_mc_grant[p*32+16 +: 16] :
                                   &sp_mc_grant[p*32+8 +: 8];
        end
    endgenerate

    // ------------------------------------------------------------
    // grant bytes
    // ------------------------------------------------------------
    logic [4:0] port_base;
    logic [8:0] sp_offs;
    logic [6:0] oq_offs;
    logic [7:0] sp_pair_a;
    logic [7:0] sp_pair_b;
    egress_grant_pkg::lane_byte_t hi_a;
    egress_grant_pkg::lane_byte_t hi_b;
    egress_grant_pkg::lane_byte_t lo_a;
    egress_grant_pkg::lane_byte_t lo_b;

    // first port n: two per step or four per step
    assign port_base = mode_512 ? {sp_port, 2'b00} : {1'b0, sp_port, 1'b0};
    assign sp_offs = {sp_type[1:0], port_base, 2'b00};
    assign sp_pair_a = sp_oq_grant[sp_offs +: 8];
    assign sp_pair_b = sp_oq_grant[9'(sp_offs + 9'h8) +: 8];
    assign oq_offs = mode_512 ? {prio_fw, ext_fw, 4'h0} : {prio_fw, 1'b0, ext_fw, 3'h0};

    // the same bytes feed data, control and service headers
    assign hi_a = grant_type ? mc_grant :
                  (sp_type == `SP_TYPE_MC) ? {spmc_upper, spmc_lower} :
                  sp_type[2] ? 8'h00 : sp_pair_a;
    assign hi_b = (!mode_512 || grant_type || sp_type[2]) ? 8'h00 : sp_pair_b;
    assign lo_a = oq_grant[oq_offs +: 8];
    assign lo_b = mode_512 ? oq_grant[7'(oq_offs + 7'h8) +: 8] : 8'h00;

    // ------------------------------------------------------------
    // qualifier, side and flow bytes
    // ------------------------------------------------------------
    egress_grant_pkg::lane_byte_t hi_h0_np;
    egress_grant_pkg::lane_byte_t lo_h0_np;
    egress_grant_pkg::lane_byte_t hi_h0;
    egress_grant_pkg::lane_byte_t lo_h0;
    egress_grant_pkg::lane_byte_t flow_b;
    logic hi_par;
    logic lo_par;

    // bit 1 left open for parity, protection held at 00
    assign hi_h0_np = {2'b00, color, 2'b00, 1'b0, grant_type};
    assign lo_h0_np = {prio_fw, color, 2'b00, 1'b0, ext_fw};
    // even parity over the qualifier byte and both grant bytes, with byte b taken as zero in 256 mode rather than the fill sent there
    assign hi_par = ^{hi_h0_np, hi_a, hi_b};
    assign lo_par = ^{lo_h0_np, lo_a, lo_b};
    assign hi_h0 = {hi_h0_np[7:2], hi_par, hi_h0_np[0]};
    assign lo_h0 = {lo_h0_np[7:2], lo_par, lo_h0_np[0]};
    assign flow_b = {sp_port, sp_type, 1'b0, mem_grant};

    // ------------------------------------------------------------
    // lane assembly
    // ------------------------------------------------------------
    logic [79:0] hi_m_nxt;
    logic [79:0] lo_m_nxt;
    logic [79:0] hi_s_nxt;
    logic [79:0] lo_s_nxt;
    logic [9:0] sync_k;

    genvar b;
    generate
        for (b = 0; b < `LANE_BYTES; b++) begin : g_byte
            if (b == `BYTE_H0) begin : g_h0
                assign hi_m_nxt[b*8 +: 8] = hi_h0;
                assign lo_m_nxt[b*8 +: 8] = lo_h0;
            end else if (b == `BYTE_H1) begin : g_h1
                assign hi_m_nxt[b*8 +: 8] = hi_a;
                assign lo_m_nxt[b*8 +: 8] = lo_a;
            end else if (b == `BYTE_H2) begin : g_h2
                assign hi_m_nxt[b*8 +: 8] = mode_512 ? hi_b : `CHAR_D21_5;
                assign lo_m_nxt[b*8 +: 8] = mode_512 ? lo_b : `CHAR_D21_5;
            end else if (b == `BYTE_SIDE) begin : g_side
                assign hi_m_nxt[b*8 +: 8] = {side_hi, side_hi};
                assign lo_m_nxt[b*8 +: 8] = {side_lo, side_lo};
            end else if (b == `BYTE_FLOW) begin : g_flow
                assign hi_m_nxt[b*8 +: 8] = flow_b;
                assign lo_m_nxt[b*8 +: 8] = flow_b;
            end else if (b == `BYTE_SYNC) begin : g_sync
                assign hi_m_nxt[b*8 +: 8] = `CHAR_K28_1;
                assign lo_m_nxt[b*8 +: 8] = `CHAR_K28_5;
            end else begin : g_fill
                assign hi_m_nxt[b*8 +: 8] = `CHAR_D21_5;
                assign lo_m_nxt[b*8 +: 8] = `CHAR_D21_5;
            end
            // slave units carry only fill and the sync character
            assign hi_s_nxt[b*8 +: 8] = (b == `BYTE_SYNC) ? `CHAR_K28_1 : `CHAR_D21_5;
            assign lo_s_nxt[b*8 +: 8] = (b == `BYTE_SYNC) ? `CHAR_K28_5 : `CHAR_D21_5;
            assign sync_k[b] = (b == `BYTE_SYNC);
        end
    endgenerate

    // ------------------------------------------------------------
    // output registers, loaded once per packet cycle
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            frame_valid_ff <= 1'b0;
            gt_last_ff <= 1'b0;
            hi_master_ff <= 80'h0;
            lo_master_ff <= 80'h0;
            hi_slave_ff <= 80'h0;
            lo_slave_ff <= 80'h0;
            hi_master_k_ff <= 10'h0;
            lo_master_k_ff <= 10'h0;
            hi_slave_k_ff <= 10'h0;
            lo_slave_k_ff <= 10'h0;
            hi_grant_a_ff <= 8'h00;
            hi_grant_b_ff <= 8'h00;
            lo_grant_a_ff <= 8'h00;
            lo_grant_b_ff <= 8'h00;
        end else begin
            frame_valid_ff <= pkt_cycle;
            if (pkt_cycle) begin
                gt_last_ff <= grant_type;
                hi_master_ff <= hi_m_nxt;
                lo_master_ff <= lo_m_nxt;
                hi_slave_ff <= hi_s_nxt;
                lo_slave_ff <= lo_s_nxt;
                hi_master_k_ff <= sync_k;
                lo_master_k_ff <= sync_k;
                hi_slave_k_ff <= sync_k;
                lo_slave_k_ff <= sync_k;
                hi_grant_a_ff <= hi_a;
                hi_grant_b_ff <= hi_b;
                lo_grant_a_ff <= lo_a;
                lo_grant_b_ff <= lo_b;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // packet cycles since the last multicast grant (grant_type high), for the period check
    logic [6:0] gap_ff;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            gap_ff <= 7'h0;
        end else if (pkt_cycle) begin
            gap_ff <= grant_type ? 7'h0 : gap_ff + 7'h1;
        end
    end

    sequence mc_slot_s;
        pkt_cycle && (sp_type == `SP_TYPE_MC);
    endsequence

    sequence flywheel_cleared_s;
        (sp_type == 3'h0) && (sp_port == 3'h0);
    endsequence

    a_third_byte_fill: assert property (
        pkt_cycle && !mode_512 |=> hi_master_ff[23:16] == `CHAR_D21_5 &&
            lo_master_ff[23:16] == `CHAR_D21_5)
        else $error("third byte not fill in 256 mode");
    a_low_sync_char: assert property (
        pkt_cycle |=> lo_master_ff[63:56] == `CHAR_K28_5 && lo_master_k_ff[7] &&
            lo_slave_ff[63:56] == `CHAR_K28_5 && !lo_master_k_ff[6])
        else $error("low channel sync character missing");
    a_fill_bytes: assert property (
        pkt_cycle |=> hi_master_ff[31:24] == `CHAR_D21_5 &&
            lo_master_ff[79:72] == `CHAR_D21_5 && hi_slave_ff[7:0] == `CHAR_D21_5)
        else $error("fill byte wrong");
    a_side_copy: assert property (
        pkt_cycle |=> hi_master_ff[47:44] == hi_master_ff[43:40] &&
            lo_master_ff[43:40] == $past(side_lo))
        else $error("side channel nibble not repeated");
    a_color_field: assert property (
        pkt_cycle |=> hi_master_ff[5:4] == $past(color) && lo_master_ff[5:4] == $past(color))
        else $error("color field wrong");
    a_protect_zero: assert property (
        pkt_cycle |=> hi_master_ff[3:2] == 2'b00 && lo_master_ff[3:2] == 2'b00)
        else $error("protection field not zero");
    a_mc_period: assert property (
        pkt_cycle && gap_ff == 7'h3c |=> hi_master_ff[0])
        else $error("periodic multicast slot missed");
    a_mc_change: assert property (
        pkt_cycle && $changed(mc_grant) && !$past(pkt_cycle) |=> hi_master_ff[0] &&
            hi_grant_a_ff == $past(mc_grant))
        else $error("multicast change not sent");
    a_mc_return: assert property (
        mc_slot_s |=> flywheel_cleared_s)
        else $error("type flywheel did not return to zero");
    a_ext_toggle: assert property (
        pkt_cycle |=> ext_fw != $past(ext_fw) && lo_master_ff[0] == $past(ext_fw))
        else $error("extended flywheel did not advance");
    a_header_parity: assert property (
        frame_valid_ff |-> ^{hi_master_ff[7:0], hi_grant_a_ff, hi_grant_b_ff} == 1'b0)
        else $error("high header parity odd");
    a_flow_byte: assert property (
        pkt_cycle |=> hi_master_ff[55:48] == {$past(sp_port), $past(sp_type), 1'b0,
            $past(mem_grant)})
        else $error("flow control byte wrong");
    a_grant_b_zero: assert property (
        pkt_cycle && (!mode_512 || sp_type[2]) |=> hi_grant_b_ff == 8'h00)
        else $error("reserved grant byte b not zero");
    a_reserved_zero: assert property (
        pkt_cycle |=> hi_master_ff[7:6] == 2'b00 && hi_master_ff[49] == 1'b0 &&
            lo_master_ff[49] == 1'b0)
        else $error("reserved header bit not zero");
endmodule

`default_nettype wire

// *** egress_adapter_model.sv ***
`default_nettype none

module egress_adapter_model (
    input wire logic mclk,
    input wire logic frame_valid_ff,
    input wire logic [79:0] hi_master_ff,
    input wire logic [79:0] lo_master_ff,
    output logic [7:0] sync_bad_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------
    // lane alignment
    // ------------------------------
    // byte 7 is the adapter's lock point, so a wrong character there means lost sync
    initial sync_bad_ff = 8'h00;
    always @(posedge mclk) begin
        if (frame_valid_ff && {hi_master_ff[63:56], lo_master_ff[63:56]} !== 16'h3cbc) begin
            sync_bad_ff <= sync_bad_ff + 8'h01;
        end
    end
endmodule

`default_nettype wire

// *** egress_idle_header_grant_formatter_bench.sv ***
`default_nettype none

module egress_idle_header_grant_formatter_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, sys_rst = 1'b1, pkt_cycle = 1'b0, mem_grant = 1'b0;
    logic [7:0] mc_grant = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [127:0] oq_grant, sp_mc_grant = ~(128'h1 << 73);
    logic [511:0] sp_oq_grant;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, frame_valid_ff;
    egress_grant_pkg::axi_resp_t s_axi_bresp, s_axi_rresp;
    logic [79:0] hi_master_ff, lo_master_ff, hi_slave_ff, lo_slave_ff;
    logic [9:0] hi_master_k_ff, lo_master_k_ff, hi_slave_k_ff, lo_slave_k_ff;
    logic [7:0] hi_grant_a_ff, hi_grant_b_ff, lo_grant_a_ff, lo_grant_b_ff, sync_bad_ff;
    int n_fail = 0, tests_run = 0;

    egress_idle_header_grant_formatter i_egress_idle_header_grant_formatter (
        .mclk, .sys_rst, .pkt_cycle, .mem_grant, .mc_grant, .oq_grant, .sp_oq_grant, .sp_mc_grant,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frame_valid_ff,
        .hi_master_ff, .hi_master_k_ff, .lo_master_ff, .lo_master_k_ff, .hi_slave_ff,
        .hi_slave_k_ff, .lo_slave_ff, .lo_slave_k_ff, .hi_grant_a_ff, .hi_grant_b_ff,
        .lo_grant_a_ff, .lo_grant_b_ff
    );
    egress_adapter_model i_egress_adapter_model (
        .mclk, .frame_valid_ff, .hi_master_ff, .lo_master_ff, .sync_bad_ff
    );

    always #2.5 mclk = ~mclk;

    // ------------------------------
    // shared tasks
    // ------------------------------
    task automatic final_report();
        if (n_fail == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int i;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (i == 20) begin
            n_fail++;
            final_report();
        end
        @(posedge mclk);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (i == 20) begin
            n_fail++;
            final_report();
        end
        @(posedge mclk);
    endtask

    // outputs are only settled once frame_valid_ff has been seen high
    task automatic pkt();
        int i;
        pkt_cycle <= 1'b1;
        @(posedge mclk);
        pkt_cycle <= 1'b0;
        for (i = 0; i < 8 && frame_valid_ff !== 1'b1; i++) @(posedge mclk);
        if (i == 8) begin
            n_fail++;
            final_report();
        end
    endtask

    // ------------------------------
    // scenarios
    // ------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic gt;
        logic [7:0] e, el, eb;
        int c, m;
        for (int i = 0; i < 64; i++) sp_oq_grant[i*8+:8] = 8'(i);
        for (int i = 0; i < 16; i++) oq_grant[i*8+:8] = 8'(i + 64);
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        axi_rd(8'h00, d, r);
        chk(d, 32'h6);
        axi_rd(8'h0c, d, r);
        chk(r, 2'h2);
        axi_wr(8'h10, 32'h1, r);
        chk(r, 2'h2);
        axi_wr(8'h04, 32'ha5, r);
        axi_wr(8'h00, 32'h36, r);
        axi_rd(8'h04, d, r);
        chk(d, 32'ha5);
        for (int p = 1; p < 134; p++) begin
            m = (p > 122);
            if (p == 123) axi_wr(8'h00, 32'h37, r);
            c = (p - 1) % 33;
            gt = (p == 3 || p % 61 == 0);
            e = gt ? 8'h96 : (c == 32 ? (m ? 8'hfb : 8'hbf) : 8'(m ? 2 * c : c + c / 8 * 8));
            eb = (c < 32) ? 8'(2 * c + 1) : 8'h00;
            el = 8'(64 + (p - 1) / 2 % 4 * 4 + (p - 1) % 2 * (m + 1));
            d = m ? {eb, eb, el + 8'h1, el + 8'h1} : 32'hb500b500;
            mem_grant <= p[0];
            mc_grant <= (p < 3) ? 8'h00 : 8'h96;
            pkt();
            chk(hi_master_ff[7:0] & 8'hfd, {7'h18, gt});
            chk(lo_master_ff[7:0] & 8'hfd, {2'((p - 1) / 2), 4'hc, 1'b0, 1'(p - 1)});
            chk({hi_master_ff[15:8], hi_grant_a_ff}, {e, e});
            chk({lo_master_ff[15:8], lo_grant_a_ff}, {el, el});
            chk(^{hi_master_ff[15:0], hi_grant_b_ff}, 1'b0);
            chk(^{lo_master_ff[15:0], lo_grant_b_ff}, 1'b0);
            chk({hi_master_ff[23:16], hi_grant_b_ff}, d[31:16]);
            chk({lo_master_ff[23:16], lo_grant_b_ff}, d[15:0]);
            chk(hi_master_ff[55:40], {3'(c), 3'(c / 8), 1'b0, p[0], 8'h55});
            chk(lo_master_ff[55:40], {3'(c), 3'(c / 8), 1'b0, p[0], 8'haa});
            chk({lo_master_ff[31:24], lo_slave_ff[7:0]}, 16'hb5b5);
            chk({lo_master_k_ff, hi_slave_k_ff}, 20'h20080);
            chk({hi_master_k_ff, lo_slave_k_ff}, 20'h20080);
            chk({hi_slave_ff[63:48], hi_master_ff[63:56]}, 24'h3cb53c);
        end
        chk(sync_bad_ff, 8'h00);
        final_report();
    end
endmodule

`default_nettype wire
